// ---- verilog/acr_config_regs.sv ----
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module acr_config_regs #(
  parameter int PULSE_CYCLES = acr_pkg::PULSE_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // conversion datapath, same clock
  input wire logic [5:0] chan_done,
  input wire logic data_consumed,
  // ready pin, three signals
  input wire logic conv_ready_pin_in,
  output logic conv_ready_pin_out,
  output logic conv_ready_pin_oe,
  // configuration towards the analog side
  output acr_pkg::acr_ready_cfg_t ready_cfg,
  output acr_pkg::acr_clock_cfg_t clock_cfg,
  output acr_pkg::acr_gain_t gain_cfg,
  output logic [15:0] osr_ratio,
  output logic high_res_mode,
  output logic irq
);

  typedef enum logic {ACR_BUS_IDLE, ACR_BUS_DATA} acr_bus_state_t;

  acr_bus_state_t bus_state_reg;
  logic [7:0] idx_reg;
  logic wr_reg;
  logic ok_reg;
  logic [15:0] mode_reg;
  logic [15:0] clock_reg;
  logic [15:0] gain_reg;
  logic [5:0] pend_reg;
  logic [acr_pkg::IRQ_W-1:0] stat_reg;
  logic [acr_pkg::IRQ_W-1:0] irq_en_reg;
  logic lag_prev_reg;
  logic any_prev_reg;
  logic [1:0] pin_sync_reg;

  logic accept;
  logic wr_en;
  logic [15:0] wdata;
  logic [5:0] en;
  logic lag_lvl;
  logic any_lvl;
  logic src_lvl;
  logic fire;
  logic pulse_active;
  logic active_now;
  logic [acr_pkg::IRQ_W-1:0] stat_next;
  logic [acr_pkg::IRQ_W-1:0] stat_set;
  logic [acr_pkg::IRQ_W-1:0] stat_clr;
  logic [5:0] pend_clr;
  logic [31:0] rd_word;

  function automatic logic wr_hit(input logic [7:0] idx, input logic [7:0] want);
    wr_hit = (idx == want);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  // one wait state per transfer keeps hrdata a flop and avoids stale reads
  assign accept = hsel && htrans[1] && hready && (bus_state_reg == ACR_BUS_IDLE);
  assign wr_en = (bus_state_reg == ACR_BUS_DATA) && wr_reg && ok_reg;
  assign wdata = hwdata[15:0];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_state_reg <= ACR_BUS_IDLE;
      hreadyout <= 1'b1;
      idx_reg <= 8'h00;
      wr_reg <= 1'b0;
      ok_reg <= 1'b0;
    end else begin
      unique case (bus_state_reg)
        ACR_BUS_IDLE: begin
          if (accept) begin
            bus_state_reg <= ACR_BUS_DATA;
            hreadyout <= 1'b0;
            idx_reg <= haddr[9:2];
            wr_reg <= hwrite;
            ok_reg <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) &&
                      (hsize == acr_pkg::HSIZE_WORD);
          end
        end
        ACR_BUS_DATA: begin
          bus_state_reg <= ACR_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // response is always okay
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // read mux; unmapped and odd-sized accesses read zero
  always_comb begin
    rd_word = 32'h00000000;
    if (ok_reg) begin
      unique case (idx_reg)
        acr_pkg::IDX_MODE: rd_word = {16'h0000, mode_reg};
        acr_pkg::IDX_CLOCK: rd_word = {16'h0000, clock_reg};
        acr_pkg::IDX_GAIN: rd_word = {16'h0000, gain_reg};
        acr_pkg::IDX_IRQ_STAT: rd_word = {30'h00000000, stat_reg};
        acr_pkg::IDX_IRQ_EN: rd_word = {30'h00000000, irq_en_reg};
        acr_pkg::IDX_CHAN_PEND: rd_word = {23'h000000, pin_sync_reg[1], 2'h0, pend_reg};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (bus_state_reg == ACR_BUS_DATA && !wr_reg) begin
      hrdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= acr_pkg::MODE_RST;
    end else if (wr_en && wr_hit(idx_reg, acr_pkg::IDX_MODE)) begin
      mode_reg <= wdata & acr_pkg::MODE_MASK;
    end
  end

  // reserved bits are dropped; software is expected to write zero there
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_reg <= acr_pkg::CLOCK_RST;
    end else if (wr_en && wr_hit(idx_reg, acr_pkg::IDX_CLOCK)) begin
      clock_reg <= wdata & acr_pkg::CLOCK_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gain_reg <= acr_pkg::GAIN_RST;
    end else if (wr_en && wr_hit(idx_reg, acr_pkg::IDX_GAIN)) begin
      gain_reg <= wdata & acr_pkg::GAIN_MASK;
    end
  end

  // configuration fields out to the converter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_cfg <= '0;
      clock_cfg <= '0;
      gain_cfg <= '0;
      osr_ratio <= acr_pkg::OSR_BASE;
      high_res_mode <= 1'b0;
    end else begin
      ready_cfg.ready_source_select <= mode_reg[acr_pkg::MODE_SEL_LSB +: 2];
      ready_cfg.ready_idle_tristate <= mode_reg[acr_pkg::MODE_HIZ_BIT];
      ready_cfg.ready_pulse_format <= mode_reg[acr_pkg::MODE_FMT_BIT];
      clock_cfg.chan_enable <= clock_reg[acr_pkg::CLK_EN_LSB +: 6];
      clock_cfg.crystal_osc_off <= clock_reg[acr_pkg::CLK_XTAL_BIT];
      clock_cfg.external_reference_select <= clock_reg[acr_pkg::CLK_EXTREF_BIT];
      clock_cfg.oversampling_ratio <= clock_reg[acr_pkg::CLK_OSR_LSB +: 3];
      clock_cfg.power_mode_select <= clock_reg[acr_pkg::CLK_PWR_LSB +: 2];
      osr_ratio <= acr_pkg::osr_decode(clock_reg[acr_pkg::CLK_OSR_LSB +: 3]);
      // codes 10 and 11 both mean high resolution
      high_res_mode <= clock_reg[acr_pkg::CLK_PWR_HIRES_BIT];
      gain_cfg <= {gain_reg[14:12], gain_reg[10:8], gain_reg[6:4], gain_reg[2:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ready source selection

  assign en = clock_reg[acr_pkg::CLK_EN_LSB +: 6];

  // host consumes results by the datapath strobe or a one-to-clear write
  assign pend_clr = {6{data_consumed}} |
                    ((wr_en && wr_hit(idx_reg, acr_pkg::IDX_CHAN_PEND)) ? wdata[5:0] : 6'h00);

  // a new result wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_reg <= 6'h00;
    end else begin
      pend_reg <= (pend_reg & ~pend_clr) | (chan_done & en);
    end
  end

  // lagging: every enabled channel has data; leading: the first has
  assign lag_lvl = (|en) && (&(pend_reg | ~en));
  assign any_lvl = |(pend_reg & en);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lag_prev_reg <= 1'b0;
      any_prev_reg <= 1'b0;
    end else begin
      lag_prev_reg <= lag_lvl;
      any_prev_reg <= any_lvl;
    end
  end

  // or mode pulses on each enabled result, leading only on the first
  always_comb begin
    if (mode_reg[acr_pkg::MODE_SEL_LSB +: 2] == acr_pkg::SEL_LAG) begin
      src_lvl = lag_lvl;
      fire = lag_lvl && !lag_prev_reg;
    end else if (mode_reg[acr_pkg::MODE_SEL_LSB +: 2] == acr_pkg::SEL_OR) begin
      src_lvl = any_lvl;
      fire = |(chan_done & en);
    end else begin
      src_lvl = any_lvl;
      fire = any_lvl && !any_prev_reg;
    end
  end

  acr_pulse_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rst(rst),
    .fire(fire && mode_reg[acr_pkg::MODE_FMT_BIT]),
    .active(pulse_active)
  );

  assign active_now = mode_reg[acr_pkg::MODE_FMT_BIT] ? pulse_active : src_lvl;

  // pin: low while active, else high or released
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conv_ready_pin_out <= 1'b1;
      conv_ready_pin_oe <= 1'b1;
    end else begin
      conv_ready_pin_out <= !active_now;
      conv_ready_pin_oe <= active_now || !mode_reg[acr_pkg::MODE_HIZ_BIT];
    end
  end

  // pin readback, two stages; software sees the wire level in the pending register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_sync_reg <= 2'h0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[0], conv_ready_pin_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign stat_set[acr_pkg::IRQ_READY_BIT] = fire;
  assign stat_set[acr_pkg::IRQ_RSVD_BIT] = wr_en &&
    ((wr_hit(idx_reg, acr_pkg::IDX_CLOCK) && |(wdata & acr_pkg::CLOCK_RSVD)) ||
     (wr_hit(idx_reg, acr_pkg::IDX_GAIN) && |(wdata & acr_pkg::GAIN_RSVD)));
  assign stat_clr = (wr_en && wr_hit(idx_reg, acr_pkg::IDX_IRQ_CLR)) ?
                    wdata[acr_pkg::IRQ_W-1:0] : '0;
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_reg <= '0;
      irq_en_reg <= '0;
      irq <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      if (wr_en && wr_hit(idx_reg, acr_pkg::IDX_IRQ_EN)) begin
        irq_en_reg <= wdata[acr_pkg::IRQ_W-1:0];
      end
      irq <= |(stat_next & irq_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [15:0] pw_cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pw_cnt_reg <= 16'h0000;
    end else begin
      pw_cnt_reg <= pulse_active ? pw_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  sequence s_accept;
    hsel && htrans[1] && hready && hreadyout;
  endsequence

  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_bus_wait_state: assert property (@(posedge sys_clk) disable iff (rst)
    s_accept |=> s_one_wait) else $error("bus transfer not one wait state");

  a_idle_drive_high: assert property (@(posedge sys_clk) disable iff (rst)
    !active_now && !mode_reg[acr_pkg::MODE_HIZ_BIT] |=> conv_ready_pin_out && conv_ready_pin_oe)
    else $error("idle ready pin not driven high");

  a_idle_float: assert property (@(posedge sys_clk) disable iff (rst)
    !active_now && mode_reg[acr_pkg::MODE_HIZ_BIT] |=> !conv_ready_pin_oe)
    else $error("idle ready pin not released");

  a_level_low: assert property (@(posedge sys_clk) disable iff (rst)
    !mode_reg[acr_pkg::MODE_FMT_BIT] && src_lvl |=> !conv_ready_pin_out && conv_ready_pin_oe)
    else $error("ready level not low");

  a_pulse_start: assert property (@(posedge sys_clk) disable iff (rst)
    fire && mode_reg[acr_pkg::MODE_FMT_BIT] |=> pulse_active ##1 !conv_ready_pin_out)
    else $error("ready pulse not started");

  a_pulse_length: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(pulse_active) |-> pw_cnt_reg >= 16'(PULSE_CYCLES))
    else $error("ready pulse too short");

  a_lag_waits: assert property (@(posedge sys_clk) disable iff (rst)
    mode_reg[acr_pkg::MODE_SEL_LSB +: 2] == acr_pkg::SEL_LAG &&
    !mode_reg[acr_pkg::MODE_FMT_BIT] && |(en & ~pend_reg) |=> conv_ready_pin_out)
    else $error("lagging source asserted early");

  a_disabled_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    chan_done[2] && !en[2] && !pend_reg[2] |=> !pend_reg[2])
    else $error("disabled channel became pending");

  a_clock_reset: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rst) |-> clock_reg == acr_pkg::CLOCK_RST && gain_reg == acr_pkg::GAIN_RST)
    else $error("clock or gain reset value wrong");

  a_osr_follows: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en && wr_hit(idx_reg, acr_pkg::IDX_CLOCK) |=> ##1
    osr_ratio == acr_pkg::osr_decode($past(wdata[4:2], 2)))
    else $error("oversampling ratio not applied");

  a_power_hires: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en && wr_hit(idx_reg, acr_pkg::IDX_CLOCK) |=> ##1 high_res_mode == $past(wdata[1], 2))
    else $error("power mode not applied");

  a_gain_write: assert property (@(posedge sys_clk) disable iff (rst)
    wr_en && wr_hit(idx_reg, acr_pkg::IDX_GAIN) |=> ##1
    gain_cfg.amp_gain_chan3 == $past(wdata[14:12], 2) &&
    gain_cfg.amp_gain_chan0 == $past(wdata[2:0], 2))
    else $error("gain code not applied");

  a_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    |(stat_reg & irq_en_reg) && stat_clr == '0 |=> irq)
    else $error("interrupt not raised");

endmodule

// ---- verilog/acr_pkg.sv ----
// Overview of operation
// - mode bits 3:2 pick ready pin source
// - idle pin high, or floating when tristate set
// - ready shows as low level or fixed pulse
// - clock bits 13:8 enable channels 5..0
// - clock bit 7 turns crystal oscillator off
// - clock bit 6 selects external reference
// - clock bits 4:2 pick oversampling ratio
// - clock bits 1:0 pick power mode
// - gain bits 14:12, 10:8 for channels 3, 2
// - gain codes for channels 1, 0 too
package acr_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'h02;
  localparam logic [7:0] IDX_CLOCK = 8'h03;
  localparam logic [7:0] IDX_GAIN = 8'h04;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h10;
  localparam logic [7:0] IDX_IRQ_EN = 8'h11;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h12;
  localparam logic [7:0] IDX_CHAN_PEND = 8'h13;

  // reset values
  localparam logic [15:0] MODE_RST = 16'h0510;
  localparam logic [15:0] CLOCK_RST = 16'h7F0E;
  localparam logic [15:0] GAIN_RST = 16'h0000;

  // writable bits; reserved bits are not stored by writes and read as zero, except clock bit 14, which reset sets
  localparam logic [15:0] MODE_MASK = 16'h3F1F;
  localparam logic [15:0] CLOCK_MASK = 16'h3FDF;
  localparam logic [15:0] GAIN_MASK = 16'h7777;
  localparam logic [15:0] CLOCK_RSVD = 16'hC020;
  localparam logic [15:0] GAIN_RSVD = 16'h8888;

  // field positions
  localparam int MODE_SEL_LSB = 2;
  localparam int MODE_HIZ_BIT = 1;
  localparam int MODE_FMT_BIT = 0;
  localparam int CLK_EN_LSB = 8;
  localparam int CLK_XTAL_BIT = 7;
  localparam int CLK_EXTREF_BIT = 6;
  localparam int CLK_OSR_LSB = 2;
  localparam int CLK_PWR_LSB = 0;
  localparam int CLK_PWR_HIRES_BIT = 1;

  // ready source codes; both remaining codes mean most leading
  localparam logic [1:0] SEL_LAG = 2'h0;
  localparam logic [1:0] SEL_OR = 2'h1;

  // interrupt status bits
  localparam int IRQ_W = 2;
  localparam int IRQ_READY_BIT = 0;
  localparam int IRQ_RSVD_BIT = 1;

  // ready pulse length in master clock cycles
  localparam int PULSE_CYCLES_DEF = 8;
  localparam int NUM_CHAN = 6;

  // oversampling ratio table
  localparam logic [15:0] OSR_BASE = 16'h0080;
  localparam logic [15:0] OSR_TOP = 16'h3F80;
  localparam logic [2:0] OSR_TOP_CODE = 3'h7;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [1:0] ready_source_select;
    logic ready_idle_tristate;
    logic ready_pulse_format;
  } acr_ready_cfg_t;

  typedef struct packed {
    logic [5:0] chan_enable;
    logic crystal_osc_off;
    logic external_reference_select;
    logic [2:0] oversampling_ratio;
    logic [1:0] power_mode_select;
  } acr_clock_cfg_t;

  typedef struct packed {
    logic [2:0] amp_gain_chan3;
    logic [2:0] amp_gain_chan2;
    logic [2:0] amp_gain_chan1;
    logic [2:0] amp_gain_chan0;
  } acr_gain_t;

  // decimation ratio from its three-bit code
  function automatic logic [15:0] osr_decode(input logic [2:0] code);
    osr_decode = (code == OSR_TOP_CODE) ? OSR_TOP : 16'(OSR_BASE << code);
  endfunction

endpackage

// ---- verilog/acr_pulse_timer.sv ----
`timescale 1ns/1ns
// fixed-length active pulse; a new fire restarts the count
module acr_pulse_timer #(
  parameter int CYCLES = acr_pkg::PULSE_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fire,
  output logic active
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_reg;

  // active for exactly CYCLES cycles after the fire edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active <= 1'b0;
      cnt_reg <= '0;
    end else if (fire) begin
      active <= 1'b1;
      cnt_reg <= LOAD;
    end else if (active) begin
      if (cnt_reg == '0) begin
        active <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule

// ---- tb/acr_host_model.sv ----
`timescale 1ns/1ns
// host side of the ready pin: resolves the wire, times low phases, fetches results
module acr_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic read_req,
  input wire logic slow,
  output logic pin_level,
  output logic data_consumed,
  output logic [7:0] low_events,
  output logic [7:0] last_low_len
);
  logic lvl_q;
  logic [7:0] run;
  logic [2:0] wait_q;
  // no pull on the wire, so a released line shows a changing pattern
  assign pin_level = pin_oe ? pin_out : ~lvl_q;
  ////////////////////////////////////////////////////////////////
  // low phases count only while the device really drives the wire
  always @(posedge sys_clk) begin
    if (rst) begin
      lvl_q <= 1'b1;
      run <= 8'h00;
      low_events <= 8'h00;
      last_low_len <= 8'h00;
    end else begin
      lvl_q <= pin_level;
      if (pin_oe && !pin_out) begin
        run <= run + 8'h01;
        if (run == 8'h00) begin
          low_events <= low_events + 8'h01;
        end
      end else if (run != 8'h00) begin
        last_low_len <= run;
        run <= 8'h00;
      end
    end
  end
  // fetching a result takes one cycle, or four when slow
  always @(posedge sys_clk) begin
    if (rst) begin
      wait_q <= 3'h0;
      data_consumed <= 1'b0;
    end else begin
      data_consumed <= (wait_q == 3'h1);
      if (read_req) begin
        wait_q <= slow ? 3'h4 : 3'h1;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

// ---- tb/adc_config_register_bank_bench.sv ----
`timescale 1ns/1ns
module adc_config_register_bank_bench;
  localparam int PCYC = 3;
  logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, irq, high_res_mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, c;
  logic [5:0] chan_done;
  logic data_consumed, pin_level, pin_out, pin_oe, read_req, slow;
  logic [7:0] low_events, last_low_len, ev;
  logic [15:0] osr_ratio, lfsr, v, g;
  logic [3:0] m;
  acr_pkg::acr_ready_cfg_t ready_cfg;
  acr_pkg::acr_clock_cfg_t clock_cfg;
  acr_pkg::acr_gain_t gain_cfg;
  int mismatches, checks;

  acr_config_regs #(.PULSE_CYCLES(PCYC)) dut_u (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .chan_done(chan_done), .data_consumed(data_consumed), .conv_ready_pin_in(pin_level),
    .conv_ready_pin_out(pin_out), .conv_ready_pin_oe(pin_oe), .ready_cfg(ready_cfg),
    .clock_cfg(clock_cfg), .gain_cfg(gain_cfg), .osr_ratio(osr_ratio),
    .high_res_mode(high_res_mode), .irq(irq));
  acr_host_model host_u (.sys_clk(sys_clk), .rst(rst), .pin_out(pin_out), .pin_oe(pin_oe),
    .read_req(read_req), .slow(slow), .pin_level(pin_level), .data_consumed(data_consumed),
    .low_events(low_events), .last_low_len(last_low_len));

  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ad(input logic [7:0] idx);
    ad = {22'h000000, idx, 2'h0};
  endfunction
  function automatic logic [15:0] exp_osr(input logic [2:0] k);
    exp_osr = (k == 3'h7) ? 16'h3F80 : 16'(16'h0080 << k);
  endfunction
  // expected {oe, out}; lagging needs every enabled channel, the others any
  function automatic logic [1:0] exp_pin(input logic [3:0] md, input logic [5:0] en,
                                         input logic [5:0] p);
    logic low;
    low = (md[3:2] == 2'h0) ? ((p & en) == en) : |(p & en);
    exp_pin = (low && !md[0]) ? 2'h2 : {~md[1], 1'b1};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single word transfer; waits for hready in both phases, only the watchdog bounds it
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [5:0] ch);
    chan_done <= ch;
    @(posedge sys_clk);
    chan_done <= 6'h00;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic consume();
    read_req <= 1'b1;
    @(posedge sys_clk);
    read_req <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic pin(input logic [5:0] p);
    chk({30'h0, pin_oe, pin_out}, {30'h0, exp_pin(m, 6'h1B, p)});
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // watchdog; the whole run needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    results;
  end

  initial begin
    {hsel, hwrite, read_req, slow} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    chan_done = 6'h00;
    mismatches = 0;
    checks = 0;
    lfsr = 16'hCC7C;
    rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // reset values
    rdchk(ad(acr_pkg::IDX_MODE), 32'h0510);
    rdchk(ad(acr_pkg::IDX_CLOCK), 32'h7F0E);
    rdchk(ad(acr_pkg::IDX_GAIN), 32'h0000);
    rdchk(ad(acr_pkg::IDX_CHAN_PEND), 32'h100);
    chk(32'(clock_cfg), 32'h1F8E);
    chk(32'(osr_ratio), 32'h0400);
    chk(32'(high_res_mode), 32'h1);
    chk(32'(ready_cfg), 32'h0);
    chk(32'(gain_cfg), 32'h0);
    chk(32'(hresp), 32'h0);
    // random fields, every ratio and gain code once, every power code twice; reserved bits zero
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      c = i[2:0];
      v = {2'h0, lfsr[13:6], 1'b0, c, c[1:0]};
      bus(1'b1, ad(acr_pkg::IDX_CLOCK), {16'h0, v});
      rdchk(ad(acr_pkg::IDX_CLOCK), {16'h0, v});
      chk(32'(clock_cfg), {19'h0, v[13:6], v[4:0]});
      chk(32'(osr_ratio), {16'h0, exp_osr(c)});
      chk(32'(high_res_mode), {31'h0, c[1]});
      g = {1'b0, c, 1'b0, lfsr[10:8], 1'b0, lfsr[6:4], 1'b0, ~c};
      bus(1'b1, ad(acr_pkg::IDX_GAIN), {16'h0, g});
      rdchk(ad(acr_pkg::IDX_GAIN), {16'h0, g});
      chk(32'(gain_cfg), {20'h0, g[14:12], g[10:8], g[6:4], g[2:0]});
    end
    // ready source codes with channels 2 and 5 disabled
    bus(1'b1, ad(acr_pkg::IDX_CLOCK), 32'h1B0E);
    for (int s = 0; s < 4; s++) begin
      m = {s[1:0], 2'h0};
      bus(1'b1, ad(acr_pkg::IDX_MODE), {28'h0001, m});
      pulse(6'h04);
      pin(6'h00);
      pulse(6'h01);
      pin(6'h01);
      pulse(6'h1A);
      pin(6'h1B);
      consume();
      pin(6'h00);
    end
    // floating idle, fixed pulse, slow host
    m = 4'h7;
    slow <= 1'b1;
    bus(1'b1, ad(acr_pkg::IDX_MODE), 32'h0017);
    // pin and fields follow the mode register one edge after the bus ends
    @(posedge sys_clk);
    chk(32'(ready_cfg), 32'h7);
    ev = low_events;
    pin(6'h00);
    pulse(6'h01);
    repeat (6) @(posedge sys_clk);
    chk(32'(last_low_len), PCYC);
    chk(32'(low_events), 32'(ev + 8'h01));
    pin(6'h01);
    consume();
    // interrupt raised, masked, cleared; reserved write flagged
    bus(1'b1, ad(acr_pkg::IDX_MODE), 32'h0014);
    bus(1'b1, ad(acr_pkg::IDX_IRQ_CLR), 32'h3);
    bus(1'b1, ad(acr_pkg::IDX_IRQ_EN), 32'h1);
    pulse(6'h01);
    chk(32'(irq), 32'h1);
    rdchk(ad(acr_pkg::IDX_IRQ_STAT), 32'h1);
    bus(1'b1, ad(acr_pkg::IDX_IRQ_EN), 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, ad(acr_pkg::IDX_IRQ_EN), 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    consume();
    bus(1'b1, ad(acr_pkg::IDX_IRQ_CLR), 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    bus(1'b1, ad(acr_pkg::IDX_CLOCK), 32'h1B2E);
    rdchk(ad(acr_pkg::IDX_CLOCK), 32'h1B0E);
    rdchk(ad(acr_pkg::IDX_IRQ_STAT), 32'h2);
    // unmapped, out of range and misaligned places
    rdchk(32'h0000002C, 32'h0);
    rdchk(32'h00000408, 32'h0);
    bus(1'b1, 32'h00000012, 32'hFFFF);
    rdchk(ad(acr_pkg::IDX_GAIN), {16'h0, g});
    results;
  end
endmodule
